// *** saw_consts.svh ***
// Purpose: Named constants for the sleep aware watchdog
// Assumes: Byte addressed Avalon-MM slave, one 32-bit word per register
// Notes:   Included by saw_wdt_counter, saw_watchdog and the testbench

`ifndef SAW_CONSTS_SVH
`define SAW_CONSTS_SVH

// ----------------------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------------------
`define SAW_OFS_CONTROL     8'h00
`define SAW_OFS_MODE        8'h04
`define SAW_OFS_CORE_STATUS 8'h08
`define SAW_OFS_EVENT       8'h0C
`define SAW_OFS_MASK        8'h10
`define SAW_OFS_COUNT       8'h14

// ----------------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------------
`define SAW_CTL_PS_MSB      5
`define SAW_CTL_PS_LSB      1
`define SAW_CTL_EN_BIT      0
`define SAW_PS_RESET        5'h0B
`define SAW_EN_RESET        1'b0
`define SAW_MODE_RESET      2'h3
`define SAW_STA_PD_BIT      0
`define SAW_STA_TO_BIT      1
`define SAW_STA_SLEEP_BIT   2
`define SAW_STA_ACTIVE_BIT  3
`define SAW_EVT_W           4
`define SAW_EVT_AWAKE_TO    0
`define SAW_EVT_SLEEP_TO    1
`define SAW_EVT_SLEEP_IN    2
`define SAW_EVT_WOKE        3

// ----------------------------------------------------------------------------
// Period select decoding and counter
// ----------------------------------------------------------------------------
`define SAW_PS_MAX          5'h12
`define SAW_PS_MIN          5'h00
`define SAW_CNT_W           23
`define SAW_CNT_FULL        23'h7FFFFF
`define SAW_CNT_ONE         23'h000001
`define SAW_CNT_ZERO        23'h000000

`endif

// *** saw_pkg.sv ***
// Purpose: Types shared by the sleep aware watchdog modules
// Assumes: Nothing beyond the constants header
// Notes:   Mode encodings follow the two-bit configuration field

package saw_pkg;

	// Watchdog operating mode field
	typedef enum logic [1:0]
	{
		SAW_MODE_OFF     = 2'b00,
		SAW_MODE_SW      = 2'b01,
		SAW_MODE_NOSLEEP = 2'b10,
		SAW_MODE_ON      = 2'b11
	} saw_mode_t;

	// Device power state seen by the watchdog
	typedef enum logic [1:0]
	{
		SAW_ST_AWAKE   = 2'b00,
		SAW_ST_ASLEEP  = 2'b01,
		SAW_ST_STARTUP = 2'b10
	} saw_state_t;

endpackage

// *** saw_sync_edge.sv ***
// Purpose: Brings the slow oscillator into the mclk domain as a tick
// Assumes: Oscillator far slower than mclk
// Notes:   Two flops of synchronisation before the edge detector

`timescale 1ns/1ns

module saw_sync_edge
	import saw_pkg::*;
(
	input  wire logic mclk,
	input  wire logic sys_rst,
	input  wire logic async_in,
	output logic      rise_tick
);

	logic meta;
	logic sync;
	logic sync_d;

	// Synchroniser chain and rising edge pulse
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			meta      <= 1'b0;
			sync      <= 1'b0;
			sync_d    <= 1'b0;
			rise_tick <= 1'b0;
		end
		else
		begin
			meta      <= async_in;
			sync      <= meta;
			sync_d    <= sync;
			rise_tick <= sync & ~sync_d;
		end
	end

endmodule

// *** saw_wdt_counter.sv ***
// Purpose: Prescaled watchdog counter with selectable terminal count
// Assumes: One osc_tick per slow oscillator rising edge
// Notes:   Clear has priority; terminal count restarts from zero

`timescale 1ns/1ns
`include "saw_consts.svh"

module saw_wdt_counter
	import saw_pkg::*;
(
	input  wire logic                 mclk,
	input  wire logic                 sys_rst,
	input  wire logic                 osc_tick,
	input  wire logic                 clear,
	input  wire logic [4:0]           period_select,
	output logic [`SAW_CNT_W-1:0]     count,
	output logic                      timeout
);

	// Last count value before wrap, i.e. 2^(5+code)-1; codes above 0x12 act as code 0
	function automatic logic [`SAW_CNT_W-1:0] saw_terminal(input logic [4:0] ps);
		logic [4:0] eff;
		eff = (ps > `SAW_PS_MAX) ? `SAW_PS_MIN : ps;
		saw_terminal = `SAW_CNT_FULL >> (`SAW_PS_MAX - eff);
	endfunction

	logic [`SAW_CNT_W-1:0] terminal;
	logic                  at_end;
	logic [`SAW_CNT_W-1:0] next_count;

	assign terminal   = saw_terminal(period_select);
	assign at_end     = osc_tick & (count == terminal);
	// Only slow oscillator edges advance the count; mclk rate is irrelevant
	assign next_count = (clear | at_end) ? `SAW_CNT_ZERO
	                  : osc_tick ? count + `SAW_CNT_ONE
	                  : count;

	// Count register and registered time-out pulse
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			count   <= `SAW_CNT_ZERO;
			timeout <= 1'b0;
		end
		else
		begin
			count   <= next_count;
			timeout <= at_end & ~clear;
		end
	end

endmodule

// *** saw_watchdog.sv ***
// Purpose: Sleep aware watchdog with Avalon-MM register access
// Assumes: Core events arrive as one-cycle pulses on mclk; slow osc is a pin
// Notes:   Time-out while awake requests a device reset, while asleep a wake
//
// The register offsets and register access over Avalon-MM were chosen for this implementation.

`timescale 1ns/1ns
`include "saw_consts.svh"

module saw_watchdog
	import saw_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        sys_rst,
	input  wire logic        low_freq_osc,
	input  wire logic [7:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        clear_watchdog_instr,
	input  wire logic        sleep_instr,
	input  wire logic        wake_req,
	input  wire logic        osc_fail,
	input  wire logic        osc_startup_timer,
	input  wire logic        sysclk_is_crystal,
	output logic             wdt_reset_req,
	output logic             wake_out,
	output logic             in_sleep,
	output logic             timeout_flag_n,
	output logic             powerdown_flag_n,
	output logic             irq
);

	// ------------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------------
	logic [4:0]              period_select;
	logic                    sw_watchdog_enable;
	saw_mode_t               watchdog_mode_cfg;
	saw_state_t              state;
	saw_state_t              next_state;
	logic [`SAW_EVT_W-1:0]   event_status;
	logic [`SAW_EVT_W-1:0]   event_mask;
	logic [`SAW_EVT_W-1:0]   event_set;
	logic [`SAW_CNT_W-1:0]   wdt_count;
	logic                    wdt_timeout;
	logic                    osc_tick;
	logic                    bus_ack;
	logic                    bus_req;
	logic                    wr_fire;
	logic                    sel_control;
	logic                    sel_mode;
	logic                    sel_core;
	logic                    sel_event;
	logic                    sel_mask;
	logic                    sel_count;
	logic [31:0]             read_mux;
	logic                    awake;
	logic                    wdt_active;
	logic                    sleep_entry;
	logic                    sleep_exit;
	logic                    timeout_awake;
	logic                    timeout_sleep;
	logic                    wdt_clear;

	// ------------------------------------------------------------------------
	// Slow oscillator tick and counter
	// ------------------------------------------------------------------------

	// Synchronised rising edge of the slow oscillator
	saw_sync_edge u_sync
	(
		.mclk      (mclk),
		.sys_rst   (sys_rst),
		.async_in  (low_freq_osc),
		.rise_tick (osc_tick)
	);

	// Prescaler and time-out counter
	saw_wdt_counter u_counter
	(
		.mclk          (mclk),
		.sys_rst       (sys_rst),
		.osc_tick      (osc_tick),
		.clear         (wdt_clear),
		.period_select (period_select),
		.count         (wdt_count),
		.timeout       (wdt_timeout)
	);

	// ------------------------------------------------------------------------
	// Avalon-MM slave: one wait state per access
	// ------------------------------------------------------------------------

	// Request decode and handshake
	assign bus_req         = avs_read | avs_write;
	assign avs_waitrequest = bus_req & ~bus_ack;
	assign wr_fire         = avs_write & bus_ack;
	assign sel_control     = (avs_address == `SAW_OFS_CONTROL);
	assign sel_mode        = (avs_address == `SAW_OFS_MODE);
	assign sel_core        = (avs_address == `SAW_OFS_CORE_STATUS);
	assign sel_event       = (avs_address == `SAW_OFS_EVENT);
	assign sel_mask        = (avs_address == `SAW_OFS_MASK);
	assign sel_count       = (avs_address == `SAW_OFS_COUNT);

	// Read data selection; unmapped addresses read zero
	always_comb
	begin
		read_mux = 32'h00000000;
		if (sel_control)
		begin
			read_mux[`SAW_CTL_PS_MSB:`SAW_CTL_PS_LSB] = period_select;
			read_mux[`SAW_CTL_EN_BIT]                 = sw_watchdog_enable;
		end
		else if (sel_mode)
		begin
			read_mux[1:0] = watchdog_mode_cfg;
		end
		else if (sel_core)
		begin
			read_mux[`SAW_STA_PD_BIT]     = powerdown_flag_n;
			read_mux[`SAW_STA_TO_BIT]     = timeout_flag_n;
			read_mux[`SAW_STA_SLEEP_BIT]  = in_sleep;
			read_mux[`SAW_STA_ACTIVE_BIT] = wdt_active;
		end
		else if (sel_event)
		begin
			read_mux[`SAW_EVT_W-1:0] = event_status;
		end
		else if (sel_mask)
		begin
			read_mux[`SAW_EVT_W-1:0] = event_mask;
		end
		else if (sel_count)
		begin
			read_mux[`SAW_CNT_W-1:0] = wdt_count;
		end
	end

	// Acknowledge flop and registered read data
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			bus_ack      <= 1'b0;
			avs_readdata <= 32'h00000000;
		end
		else
		begin
			bus_ack <= bus_req & ~bus_ack;
			if (avs_read & ~bus_ack)
			begin
				avs_readdata <= read_mux;
			end
		end
	end

	// ------------------------------------------------------------------------
	// Software registers
	// ------------------------------------------------------------------------

	// Control, mode and mask registers
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			period_select      <= `SAW_PS_RESET;
			sw_watchdog_enable <= `SAW_EN_RESET;
			watchdog_mode_cfg  <= saw_mode_t'(`SAW_MODE_RESET);
			event_mask         <= {`SAW_EVT_W{1'b0}};
		end
		else if (wr_fire)
		begin
			if (sel_control)
			begin
				period_select      <= avs_writedata[`SAW_CTL_PS_MSB:`SAW_CTL_PS_LSB];
				sw_watchdog_enable <= avs_writedata[`SAW_CTL_EN_BIT];
			end
			if (sel_mode)
			begin
				watchdog_mode_cfg <= saw_mode_t'(avs_writedata[1:0]);
			end
			if (sel_mask)
			begin
				event_mask <= avs_writedata[`SAW_EVT_W-1:0];
			end
		end
	end

	// ------------------------------------------------------------------------
	// Mode decoding and clear conditions
	// ------------------------------------------------------------------------

	// Watchdog activity from mode, enable and power state
	assign awake      = (state != SAW_ST_ASLEEP);
	assign wdt_active = (watchdog_mode_cfg == SAW_MODE_ON)
	                  | ((watchdog_mode_cfg == SAW_MODE_NOSLEEP) & awake)
	                  | ((watchdog_mode_cfg == SAW_MODE_SW)
	                     & sw_watchdog_enable);

	// Power state transitions and time-out routing
	assign sleep_entry   = (state == SAW_ST_AWAKE) & sleep_instr;
	assign timeout_sleep = (state == SAW_ST_ASLEEP) & wdt_timeout & wdt_active;
	assign sleep_exit    = (state == SAW_ST_ASLEEP) & (wake_req | wdt_timeout & wdt_active);
	assign timeout_awake = awake & wdt_timeout & wdt_active;

	// Every condition that clears counter and prescaler
	assign wdt_clear = ~wdt_active
	                 | clear_watchdog_instr
	                 | osc_fail
	                 | osc_startup_timer
	                 | sleep_entry
	                 | sleep_exit
	                 | (state == SAW_ST_STARTUP);

	// ------------------------------------------------------------------------
	// Power state machine
	// ------------------------------------------------------------------------

	// Next state; crystal clocks hold through oscillator start-up
	always_comb
	begin
		next_state = state;
		case (state)
			SAW_ST_AWAKE:
			begin
				if (sleep_instr)
				begin
					next_state = SAW_ST_ASLEEP;
				end
			end
			SAW_ST_ASLEEP:
			begin
				if (sleep_exit)
				begin
					next_state = sysclk_is_crystal ? SAW_ST_STARTUP : SAW_ST_AWAKE;
				end
			end
			SAW_ST_STARTUP:
			begin
				if (~osc_startup_timer)
				begin
					next_state = SAW_ST_AWAKE;
				end
			end
			default:
			begin
				next_state = SAW_ST_AWAKE;
			end
		endcase
	end

	// State register
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= SAW_ST_AWAKE;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ------------------------------------------------------------------------
	// Core status flags and event outputs
	// ------------------------------------------------------------------------

	// Active-low time-out and power-down flags
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end
		else if (timeout_awake)
		begin
			timeout_flag_n <= 1'b0;
		end
		else if (timeout_sleep)
		begin
			timeout_flag_n   <= 1'b0;
			powerdown_flag_n <= 1'b0;
		end
		else if (sleep_entry)
		begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b0;
		end
		else if (clear_watchdog_instr & awake)
		begin
			timeout_flag_n   <= 1'b1;
			powerdown_flag_n <= 1'b1;
		end
	end

	// Reset request, wake pulse and sleep level
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wdt_reset_req <= 1'b0;
			wake_out      <= 1'b0;
			in_sleep      <= 1'b0;
		end
		else
		begin
			wdt_reset_req <= timeout_awake;
			wake_out      <= sleep_exit;
			in_sleep      <= (next_state == SAW_ST_ASLEEP);
		end
	end

	// ------------------------------------------------------------------------
	// Interrupt status, write one to clear, set wins
	// ------------------------------------------------------------------------

	// Event sources for sticky status bits
	always_comb
	begin
		event_set                    = {`SAW_EVT_W{1'b0}};
		event_set[`SAW_EVT_AWAKE_TO] = timeout_awake;
		event_set[`SAW_EVT_SLEEP_TO] = timeout_sleep;
		event_set[`SAW_EVT_SLEEP_IN] = sleep_entry;
		event_set[`SAW_EVT_WOKE]     = sleep_exit;
	end

	// Sticky status register
	always_ff @(posedge mclk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			event_status <= {`SAW_EVT_W{1'b0}};
		end
		else if (wr_fire & sel_event)
		begin
			event_status <= (event_status & ~avs_writedata[`SAW_EVT_W-1:0]) | event_set;
		end
		else
		begin
			event_status <= event_status | event_set;
		end
	end

	// Level interrupt from unmasked events
	assign irq = |(event_status & event_mask);

endmodule

// *** saw_watchdog_checker.sv ***
// Purpose: Port level checks of the sleep aware watchdog
// Assumes: One clock domain, reset active high
// Notes:   Bound to saw_watchdog from the testbench top
`timescale 1ns/1ns
module saw_watchdog_checker
	import saw_pkg::*;
(
	input wire logic	mclk,
	input wire logic	sys_rst,
	input wire logic	avs_read,
	input wire logic	avs_write,
	input wire logic	avs_waitrequest,
	input wire logic	sleep_instr,
	input wire logic	wake_req,
	input wire logic	osc_fail,
	input wire logic	osc_startup_timer,
	input wire logic	wdt_reset_req,
	input wire logic	wake_out,
	input wire logic	in_sleep,
	input wire logic	timeout_flag_n,
	input wire logic	powerdown_flag_n
);
	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	// Single clock domain for all checks
	default clocking cb @(posedge mclk); endclocking
	default disable iff (sys_rst);

	a_wait_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer late");
	a_wait_idle: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
		else $error("wait while idle");
	a_rst_awake: assert property (wdt_reset_req |-> !in_sleep && !wake_out)
		else $error("reset request while asleep");
	a_rst_pulse: assert property (wdt_reset_req |=> !wdt_reset_req)
		else $error("reset request too long");
	a_rst_flag: assert property (wdt_reset_req |-> !timeout_flag_n)
		else $error("time-out flag not cleared");
	a_wake_awake: assert property (wake_out |-> !in_sleep && !wdt_reset_req)
		else $error("wake pulse while asleep");
	a_sleep_flags: assert property ($rose(in_sleep) |-> !powerdown_flag_n && timeout_flag_n)
		else $error("flags wrong on sleep entry");
	a_sleep_entry: assert property (sleep_instr && !in_sleep && !wake_req && !wake_out
		&& !osc_startup_timer && !$past(osc_startup_timer) |=> in_sleep)
		else $error("sleep not entered");
	a_fail_quiet: assert property (osc_fail [*4] |-> !wdt_reset_req && (!wake_out || $past(wake_req)))
		else $error("time-out during osc fail");
	a_startup_quiet: assert property (osc_startup_timer [*4] |-> !wdt_reset_req)
		else $error("time-out during start-up");

	// Main scenarios reached
	c_awake_to: cover property (wdt_reset_req);
	c_sleep_to: cover property (wake_out && !powerdown_flag_n);
	c_sleep_in: cover property ($rose(in_sleep));
	c_fail: cover property (osc_fail [*4]);
endmodule

// *** sleep_aware_watchdog_tb.sv ***
// Purpose: Self-checking bench of the sleep aware watchdog
// Assumes: Slow oscillator driven as 16 mclk per edge
// Notes:   Period codes 0 and 1 keep every time-out short; codes 0x13 and 0x1F act as code 0
`timescale 1ns/1ns
`include "saw_consts.svh"
module sleep_aware_watchdog_tb
	import saw_pkg::*;
;
	logic		mclk = '0;
	logic		sys_rst = 1'h1;
	logic		low_freq_osc = '0;
	logic [7:0]	avs_address = '0;
	logic		avs_read = '0;
	logic		avs_write = '0;
	logic [31:0]	avs_writedata = '0;
	logic		clear_watchdog_instr = '0;
	logic		sleep_instr = '0;
	logic		wake_req = '0;
	logic		osc_fail = '0;
	logic		osc_startup_timer = '0;
	logic		sysclk_is_crystal = '0;
	logic [31:0]	avs_readdata;
	logic		avs_waitrequest, wdt_reset_req, wake_out, in_sleep;
	logic		timeout_flag_n, powerdown_flag_n, irq;
	int		errors = 0, n_compared = 0, n_rst = 0, n_wake = 0, cyc = 0;
	logic [4:0]	codes [4] = '{5'h00, 5'h01, 5'h13, 5'h1F};
	int		lens [4] = '{32, 64, 32, 32};
	logic [1:0]	modes [5] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3};
	int		on_awake [5] = '{0, 0, 5, 5, 5};
	int		on_sleep [5] = '{0, 0, 5, 0, 5};

	saw_watchdog dut_u
	(
		.mclk                 (mclk),
		.sys_rst              (sys_rst),
		.low_freq_osc         (low_freq_osc),
		.avs_address          (avs_address),
		.avs_read             (avs_read),
		.avs_write            (avs_write),
		.avs_writedata        (avs_writedata),
		.avs_readdata         (avs_readdata),
		.avs_waitrequest      (avs_waitrequest),
		.clear_watchdog_instr (clear_watchdog_instr),
		.sleep_instr          (sleep_instr),
		.wake_req             (wake_req),
		.osc_fail             (osc_fail),
		.osc_startup_timer    (osc_startup_timer),
		.sysclk_is_crystal    (sysclk_is_crystal),
		.wdt_reset_req        (wdt_reset_req),
		.wake_out             (wake_out),
		.in_sleep             (in_sleep),
		.timeout_flag_n       (timeout_flag_n),
		.powerdown_flag_n     (powerdown_flag_n),
		.irq                  (irq)
	);

	// Clock
	always #2 mclk = ~mclk;

	// Pulse counters and run ceiling
	always @(negedge mclk)
	begin
		cyc++;
		if (wdt_reset_req === 1'b1)
			n_rst++;
		if (wake_out === 1'b1)
			n_wake++;
		if (cyc == 30000)
		begin
			errors++;
			report_and_stop;
		end
	end

	task report_and_stop;
		$display("errors %0d compared %0d", errors, n_compared);
		if (errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Comparisons
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			errors++;
			$display("ERROR %0t value %h expected %h", $time, got, exp);
		end
	endtask
	task bit_chk(input logic got, input logic exp);
		chk({31'h0, got}, {31'h0, exp});
	endtask
	task cnt_chk(input int got, input int exp);
		chk(got, exp);
	endtask

	// Avalon access, held until waitrequest sampled low at a rising edge
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge mclk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do
		begin
			@(posedge mclk);
		end
		while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// One more edge so outputs launched by the access have settled
		@(posedge mclk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task rd_chk(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, exp);
	endtask

	// Core event pulse: 0 clear, 1 sleep, 2 wake
	task pulse(input int k);
		@(posedge mclk);
		case (k)
			0: clear_watchdog_instr <= 1'b1;
			1: sleep_instr <= 1'b1;
			default: wake_req <= 1'b1;
		endcase
		@(posedge mclk);
		clear_watchdog_instr <= 1'b0;
		sleep_instr <= 1'b0;
		wake_req <= 1'b0;
		// Flags launched by the pulse are settled at the next edge
		@(posedge mclk);
	endtask

	// Slow oscillator rising edges
	task edges(input int n);
		repeat (n)
		begin
			repeat (8) @(posedge mclk);
			low_freq_osc <= 1'b1;
			repeat (8) @(posedge mclk);
			low_freq_osc <= 1'b0;
		end
	endtask

	// Time-out after exactly len edges, awake or asleep
	task measure(input logic [4:0] code, input int len, input logic sl);
		int r0;
		int w0;
		wr(`SAW_OFS_CONTROL, {26'h0, code, 1'b0});
		pulse(sl ? 1 : 0);
		r0 = n_rst;
		w0 = n_wake;
		edges(len - 1);
		rd_chk(`SAW_OFS_COUNT, len - 1);
		cnt_chk(n_rst + n_wake, r0 + w0);
		edges(1);
		cnt_chk(n_rst, r0 + (sl ? 0 : 1));
		cnt_chk(n_wake, w0 + (sl ? 1 : 0));
	endtask

	// Main sequence
	initial
	begin
		repeat (16) @(posedge mclk);
		sys_rst <= 1'b0;
		rd_chk(`SAW_OFS_CONTROL, 32'h16);
		rd_chk(`SAW_OFS_MODE, 32'h3);
		rd_chk(`SAW_OFS_CORE_STATUS, 32'hB);
		rd_chk(`SAW_OFS_COUNT, 32'h0);
		rd_chk(8'h20, 32'h0);
		wr(`SAW_OFS_CONTROL, 32'hFFFFFFFF);
		rd_chk(`SAW_OFS_CONTROL, 32'h3F);
		wr(`SAW_OFS_CONTROL, 32'h0);
		pulse(0);
		edges(20);
		pulse(0);
		edges(31);
		rd_chk(`SAW_OFS_COUNT, 32'h1F);
		for (int i = 0; i < 4; i++)
		begin
			wr(`SAW_OFS_MASK, {31'h0, i[0]});
			measure(codes[i], lens[i], 1'b0);
			bit_chk(timeout_flag_n, 1'b0);
			rd_chk(`SAW_OFS_COUNT, 32'h0);
			rd_chk(`SAW_OFS_EVENT, 32'h1);
			bit_chk(irq, i[0]);
			wr(`SAW_OFS_EVENT, 32'hF);
			bit_chk(irq, 1'b0);
		end
		measure(5'h00, 32, 1'b1);
		bit_chk(in_sleep, 1'b0);
		bit_chk(timeout_flag_n, 1'b0);
		bit_chk(powerdown_flag_n, 1'b0);
		rd_chk(`SAW_OFS_EVENT, 32'hE);
		wr(`SAW_OFS_EVENT, 32'hF);
		for (int i = 0; i < 5; i++)
		begin
			wr(`SAW_OFS_MODE, {30'h0, modes[i]});
			wr(`SAW_OFS_CONTROL, {31'h0, i == 0 || i == 2});
			pulse(0);
			edges(5);
			rd_chk(`SAW_OFS_COUNT, on_awake[i]);
			pulse(1);
			bit_chk(timeout_flag_n, 1'b1);
			bit_chk(powerdown_flag_n, 1'b0);
			edges(5);
			rd_chk(`SAW_OFS_COUNT, on_sleep[i]);
			pulse(2);
			rd_chk(`SAW_OFS_COUNT, 32'h0);
		end
		sysclk_is_crystal <= 1'b1;
		osc_startup_timer <= 1'b1;
		pulse(1);
		pulse(2);
		edges(5);
		rd_chk(`SAW_OFS_COUNT, 32'h0);
		osc_startup_timer <= 1'b0;
		edges(5);
		rd_chk(`SAW_OFS_COUNT, 32'h5);
		osc_fail <= 1'b1;
		edges(5);
		rd_chk(`SAW_OFS_COUNT, 32'h0);
		osc_fail <= 1'b0;
		report_and_stop;
	end
endmodule

bind saw_watchdog saw_watchdog_checker chk_u
(
	.mclk              (mclk),
	.sys_rst           (sys_rst),
	.avs_read          (avs_read),
	.avs_write         (avs_write),
	.avs_waitrequest   (avs_waitrequest),
	.sleep_instr       (sleep_instr),
	.wake_req          (wake_req),
	.osc_fail          (osc_fail),
	.osc_startup_timer (osc_startup_timer),
	.wdt_reset_req     (wdt_reset_req),
	.wake_out          (wake_out),
	.in_sleep          (in_sleep),
	.timeout_flag_n    (timeout_flag_n),
	.powerdown_flag_n  (powerdown_flag_n)
);
